// *** rtl/sspg_pkg.sv ***
// Package: register map, field layout and constants for the spread profile generator
package sspg_pkg;

   // APB register offsets (byte addresses)
   localparam logic [7:0] SSPG_CTRL_OFS = 8'h00;
   localparam logic [7:0] SSPG_SHAPE_LO_OFS = 8'h04;
   localparam logic [7:0] SSPG_SHAPE_HI_OFS = 8'h08;
   localparam logic [7:0] SSPG_STATUS_OFS = 8'h0c;

   // Control register fields
   localparam int SSPG_STEP_LSB = 0;
   localparam int SSPG_STEP_W = 4;
   localparam int SSPG_NSAMP_LSB = 4;
   localparam int SSPG_NSAMP_W = 3;
   localparam int SSPG_OFFSET_LSB = 8;
   localparam int SSPG_OFFSET_W = 6;
   localparam int SSPG_DITHER_BIT = 16;
   localparam int SSPG_DOUBLE_BIT = 17;

   // Shape samples: twelve four-bit deltas
   localparam int SSPG_NUM_SAMPLES = 12;
   localparam int SSPG_SAMPLE_W = 4;
   localparam int SSPG_SAMPLES_PER_WORD = 8;

   // Effective count arithmetic
   localparam int SSPG_NSAMP_MULT = 2;
   localparam int SSPG_STEP_ADD = 2;
   localparam int SSPG_QUADRANTS = 4;

   // Output value width (offset plus doubled sum, with headroom)
   localparam int SSPG_VALUE_W = 8;

   // Reset values
   localparam logic [31:0] SSPG_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] SSPG_SHAPE_RST = 32'h0000_0000;
   localparam logic [15:0] SSPG_LFSR_SEED = 16'hace1;

   typedef enum logic [1:0] {
      SSPG_Q_UP_POS,
      SSPG_Q_DOWN_POS,
      SSPG_Q_UP_NEG,
      SSPG_Q_DOWN_NEG
   } sspg_quad_e;

endpackage : sspg_pkg

// *** rtl/sspg_lfsr.sv ***
// Free-running pseudo-random bit source for dithering
module sspg_lfsr
   import sspg_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Random output
   output logic rand_bit
);
   logic [15:0] lfsr_q;

   // Taps 16,14,13,11: maximal length
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         lfsr_q <= SSPG_LFSR_SEED;
      end
      else
      begin
         lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      end
   end

   assign rand_bit = lfsr_q[0];
endmodule : sspg_lfsr

// *** rtl/sspg_top.sv ***
// Spread spectrum profile generator with APB configuration registers
//
// The APB interface to the registers and the address map were decided locally.
module sspg_top
   import sspg_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Modulator feed
   output logic signed [sspg_pkg::SSPG_VALUE_W:0] mod_value,
   output logic mod_active
);
   import sspg_pkg::*;

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [31:0] ctrl_q;
   logic [31:0] shape_lo_q;
   logic [31:0] shape_hi_q;

   logic [SSPG_STEP_W-1:0] step_field;
   logic [SSPG_NSAMP_W-1:0] nsamp_field;
   logic [SSPG_OFFSET_W-1:0] offset_field;
   logic dither_enable;
   logic amplitude_double;
   logic [SSPG_SAMPLE_W-1:0] delta_shape_sample [SSPG_NUM_SAMPLES];

   assign step_field = ctrl_q[SSPG_STEP_LSB +: SSPG_STEP_W];
   assign nsamp_field = ctrl_q[SSPG_NSAMP_LSB +: SSPG_NSAMP_W];
   assign offset_field = ctrl_q[SSPG_OFFSET_LSB +: SSPG_OFFSET_W];
   assign dither_enable = ctrl_q[SSPG_DITHER_BIT];
   assign amplitude_double = ctrl_q[SSPG_DOUBLE_BIT];

   // Unpack twelve deltas from two words
   genvar gi;
   generate
      for (gi = 0; gi < SSPG_NUM_SAMPLES; gi++)
      begin : g_samp
         if (gi < SSPG_SAMPLES_PER_WORD)
         begin : g_lo
            assign delta_shape_sample[gi] = shape_lo_q[gi*SSPG_SAMPLE_W +: SSPG_SAMPLE_W];
         end
         else
         begin : g_hi
            assign delta_shape_sample[gi] =
               shape_hi_q[(gi-SSPG_SAMPLES_PER_WORD)*SSPG_SAMPLE_W +: SSPG_SAMPLE_W];
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // APB slave: one wait state, error on unmapped address
   // ------------------------------------------------------------
   logic apb_access;
   logic addr_hit;
   assign apb_access = psel && penable && !pready;

   always_comb
   begin
      if (paddr == SSPG_CTRL_OFS)
      begin
         addr_hit = 1'b1;
      end
      else if (paddr == SSPG_SHAPE_LO_OFS)
      begin
         addr_hit = 1'b1;
      end
      else if (paddr == SSPG_SHAPE_HI_OFS)
      begin
         addr_hit = 1'b1;
      end
      else if (paddr == SSPG_STATUS_OFS)
      begin
         addr_hit = 1'b1;
      end
      else
      begin
         addr_hit = 1'b0;
      end
   end

   // Ready pulses one cycle into the access phase
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= apb_access;
         pslverr <= apb_access && !addr_hit;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         ctrl_q <= SSPG_CTRL_RST;
         shape_lo_q <= SSPG_SHAPE_RST;
         shape_hi_q <= SSPG_SHAPE_RST;
      end
      else if (apb_access && pwrite)
      begin
         if (paddr == SSPG_CTRL_OFS)
         begin
            ctrl_q <= pwdata & 32'h0003_3f7f;
         end
         else if (paddr == SSPG_SHAPE_LO_OFS)
         begin
            shape_lo_q <= pwdata;
         end
         else if (paddr == SSPG_SHAPE_HI_OFS)
         begin
            shape_hi_q <= {16'h0000, pwdata[15:0]};
         end
      end
   end

   // ------------------------------------------------------------
   // Profile sequencer
   // ------------------------------------------------------------
   sspg_quad_e quad_q;
   logic [4:0] step_cnt_q;
   logic [3:0] samp_idx_q;
   logic [6:0] acc_q;
   logic [4:0] step_len;
   logic [3:0] nsamp_eff;
   logic enable;
   logic step_done;
   logic last_samp;
   logic first_samp;

   assign enable = (step_field != '0);
   assign step_len = 5'(step_field) + 5'(SSPG_STEP_ADD);
   assign nsamp_eff = 4'(nsamp_field) * 4'(SSPG_NSAMP_MULT);
   assign step_done = (step_cnt_q == step_len - 5'd1);
   assign last_samp = (samp_idx_q == nsamp_eff - 4'd1);
   assign first_samp = (samp_idx_q == 4'd0);

   // Step timer
   always_ff @(posedge mclk)
   begin
      if (srst || !enable)
      begin
         step_cnt_q <= '0;
      end
      else if (step_done)
      begin
         step_cnt_q <= '0;
      end
      else
      begin
         step_cnt_q <= step_cnt_q + 5'd1;
      end
   end

   // Quadrant walk: up adds deltas, down removes them in reverse; each quadrant
   // holds nsamp_eff steps so a cycle is 4 * Nssc * Tssc detector cycles
   always_ff @(posedge mclk)
   begin
      if (srst || !enable)
      begin
         quad_q <= SSPG_Q_UP_POS;
         samp_idx_q <= '0;
         acc_q <= '0;
      end
      else if (step_done)
      begin
         case (quad_q)
            SSPG_Q_UP_POS, SSPG_Q_UP_NEG:
            begin
               acc_q <= acc_q + 7'(delta_shape_sample[samp_idx_q]);
               if (last_samp)
               begin
                  quad_q <= (quad_q == SSPG_Q_UP_POS) ? SSPG_Q_DOWN_POS : SSPG_Q_DOWN_NEG;
               end
               else
               begin
                  samp_idx_q <= samp_idx_q + 4'd1;
               end
            end
            default:
            begin
               acc_q <= acc_q - 7'(delta_shape_sample[samp_idx_q]);
               if (first_samp)
               begin
                  quad_q <= (quad_q == SSPG_Q_DOWN_POS) ? SSPG_Q_UP_NEG : SSPG_Q_UP_POS;
               end
               else
               begin
                  samp_idx_q <= samp_idx_q - 4'd1;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Output value
   // ------------------------------------------------------------
   logic rand_bit;
   logic signed [SSPG_VALUE_W:0] swing;
   logic signed [SSPG_VALUE_W:0] value_d;

   sspg_lfsr u_lfsr
   (
      .mclk(mclk),
      .srst(srst),
      .rand_bit(rand_bit)
   );

   always_comb
   begin
      swing = amplitude_double ? $signed({1'b0, acc_q, 1'b0})
                               : $signed({2'b00, acc_q});
      if (quad_q == SSPG_Q_UP_NEG || quad_q == SSPG_Q_DOWN_NEG)
      begin
         swing = -swing;
      end
      // Offset shifts the centre; zero offset leaves centre spread
      value_d = $signed({3'b000, offset_field}) + swing;
      if (dither_enable)
      begin
         value_d[0] = value_d[0] ^ rand_bit;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         mod_value <= '0;
         mod_active <= 1'b0;
      end
      else
      begin
         mod_value <= enable ? value_d : '0;
         mod_active <= enable;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         prdata <= '0;
      end
      else if (apb_access && !pwrite)
      begin
         if (paddr == SSPG_CTRL_OFS)
         begin
            prdata <= ctrl_q;
         end
         else if (paddr == SSPG_SHAPE_LO_OFS)
         begin
            prdata <= shape_lo_q;
         end
         else if (paddr == SSPG_SHAPE_HI_OFS)
         begin
            prdata <= shape_hi_q;
         end
         else if (paddr == SSPG_STATUS_OFS)
         begin
            prdata <= {13'h0000, enable, quad_q, samp_idx_q, 5'h00, acc_q};
         end
         else
         begin
            prdata <= '0;
         end
      end
   end
endmodule : sspg_top

// *** test/sspg_checker.sv ***
// Checker: port properties of the spread profile generator
module sspg_checker
   import sspg_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Feed
   input wire logic signed [sspg_pkg::SSPG_VALUE_W:0] mod_value,
   input wire logic mod_active
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [17:0] ctl_q;
   logic [7:0] qt_q;
   logic [7:0] run_q;
   logic take;
   logic ok;
   logic [3:0] st;
   assign take = psel && penable && !pready;
   assign st = ctl_q[3:0];
   // Dither moves bit 0 off the step grid
   assign ok = qt_q > 8'h4 && st != 4'h0 && !ctl_q[SSPG_DITHER_BIT];
   // Shadow lags the design, hence the settle count
   always_ff @(posedge mclk)
   begin
      if (srst || (pready && pwrite))
         qt_q <= 8'h0;
      else if (qt_q != 8'hff)
         qt_q <= qt_q + 8'h1;
   end
   always_ff @(posedge mclk)
   begin
      if (srst)
         ctl_q <= 18'h0;
      else if (pready && pwrite && paddr == SSPG_CTRL_OFS)
         ctl_q <= pwdata[17:0];
   end
   always_ff @(posedge mclk)
   begin
      if (srst || $changed(mod_value))
         run_q <= 8'h1;
      else if (run_q != 8'hff)
         run_q <= run_q + 8'h1;
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   property p_answer;
      take |=> pready;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_pulse;
      pready |=> !pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("ready too long");
   property p_unmap;
      take && paddr > 8'h0c |=> pslverr;
   endproperty
   a_unmap: assert property (p_unmap) else $error("no slave error");
   property p_off;
      qt_q > 8'h4 && st == 4'h0 |-> !mod_active && mod_value == 0;
   endproperty
   a_off: assert property (p_off) else $error("feed not idle");
   property p_on;
      qt_q > 8'h4 && st != 4'h0 |-> mod_active;
   endproperty
   a_on: assert property (p_on) else $error("feed not active");
   property p_step;
      ok && $changed(mod_value) && {1'h0, run_q} + 9'h8 < {1'h0, qt_q}
         |-> run_q % (st + 8'h2) == 8'h0;
   endproperty
   a_step: assert property (p_step) else $error("step length");
   property p_dbl;
      ok && ctl_q[SSPG_DOUBLE_BIT] |-> mod_value[0] == ctl_q[SSPG_OFFSET_LSB];
   endproperty
   a_dbl: assert property (p_dbl) else $error("odd doubled swing");
   property p_rst;
      $fell(srst) |-> !mod_active && mod_value == 0 && !pready;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   c_err: cover property (pready && pslverr);
   c_dbl: cover property (ok && ctl_q[SSPG_DOUBLE_BIT] && mod_active);
   c_dither_enable: cover property (mod_active && ctl_q[SSPG_DITHER_BIT]);
endmodule : sspg_checker
bind sspg_top sspg_checker sspg_checker_inst (.mclk, .srst, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .mod_value, .mod_active);

// *** test/sspg_fbdiv_model.sv ***
// Feedback divider stand-in: tracks the span of the feed
module sspg_fbdiv_model
   import sspg_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic clr,
   // Feed and span
   // Feed stands in for the fractional part of the multiplier
   input wire logic signed [sspg_pkg::SSPG_VALUE_W:0] mod_value,
   output logic signed [sspg_pkg::SSPG_VALUE_W:0] hi_q,
   output logic signed [sspg_pkg::SSPG_VALUE_W:0] lo_q
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge mclk)
   begin
      if (clr || mod_value > hi_q)
         hi_q <= mod_value;
      if (clr || mod_value < lo_q)
         lo_q <= mod_value;
   end
endmodule : sspg_fbdiv_model

// *** test/tb.sv ***
// Testbench: bus traffic and waveform checks
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sspg_pkg::*;
   logic mclk = 1'h0;
   logic srst = 1'h1;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic clr = 1'h0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, mod_active;
   logic signed [SSPG_VALUE_W:0] mod_value, hi, lo;
   logic signed [SSPG_VALUE_W:0] a[768];
   logic [32:0] exp_q[$];
   int fails = 0;
   int n_tests = 0;
   always #2.5 mclk = ~mclk;
   sspg_top sspg_top_inst (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .mod_value, .mod_active);
   sspg_fbdiv_model sspg_fbdiv_model_inst (.mclk, .clr, .mod_value, .hi_q(hi), .lo_q(lo));
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict();
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
      input logic [32:0] e);
      @(posedge mclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      if (!w)
         exp_q.push_back(e);
      @(posedge mclk);
      penable <= 1'h1;
      do
         @(posedge mclk);
      while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   always @(posedge mclk)
   begin
      if (pready === 1'h1 && pwrite === 1'h0)
         chk({pslverr, prdata}, exp_q.pop_front());
   end
   initial
   begin
      repeat (20000) @(posedge mclk);
      fails++;
      print_verdict();
   end
   initial
   begin
      int st, ns, off, tot, p, nd;
      logic [47:0] sh;
      logic [31:0] c;
      logic [8:0] m;
      void'($urandom(37));
      repeat (20) @(posedge mclk);
      srst <= 1'h0;
      // Reset values, then one unmapped word
      for (int i = 0; i < 5; i++)
         apb(1'h0, 8'(i * 4), 32'h0, {i == 4, 32'h0});
      for (int r = 0; r < 3; r++)
      begin
         // Stop before reshaping: a live walk would keep stale deltas in the sum
         apb(1'h1, SSPG_CTRL_OFS, 32'h0, 33'h0);
         apb(1'h0, SSPG_STATUS_OFS, 32'h0, 33'h0);
         st = 5 + $urandom % 10;
         ns = 1 + $urandom % 6;
         off = $urandom % 28;
         tot = 0;
         for (int i = 0; i < 12; i++)
         begin
            sh[i*4 +: 4] = 4'(1 + $urandom % 3);
            if (i < 2 * ns)
               tot += sh[i*4 +: 4];
         end
         c = {14'h0, r > 0, r > 1, 2'h0, 6'(off), 1'h0, 3'(ns), 4'(st)};
         apb(1'h1, SSPG_SHAPE_LO_OFS, sh[31:0], 33'h0);
         apb(1'h1, SSPG_SHAPE_HI_OFS, {16'h0, sh[47:32]}, 33'h0);
         apb(1'h1, SSPG_CTRL_OFS, c, 33'h0);
         apb(1'h0, SSPG_CTRL_OFS, 32'h0, {1'h0, c});
         p = 8 * ns * (st + 2);
         repeat (p) @(posedge mclk);
         clr <= 1'h1;
         @(posedge mclk);
         clr <= 1'h0;
         m = r > 1 ? 9'h1fe : 9'h1ff;
         nd = 0;
         for (int i = 0; i < p; i++)
         begin
            @(posedge mclk);
            a[i] = mod_value;
         end
         for (int i = 0; i < p; i++)
         begin
            @(posedge mclk);
            chk(mod_value & m, a[i] & m);
            nd += int'(mod_value[0] !== 1'(off));
         end
         chk(mod_active, 1'h1);
         if (r > 1)
            chk(nd != 0, 1'h1);
         else
         begin
            chk(hi, 9'(off + (r + 1) * tot));
            chk(lo, 9'(off - (r + 1) * tot));
            for (int i = 0; i < p / 2; i++)
               chk(9'(a[i] + a[i + p / 2]), 9'(2 * off));
         end
      end
      apb(1'h1, SSPG_CTRL_OFS, 32'h0, 33'h0);
      repeat (4) @(posedge mclk);
      chk(mod_value, 33'h0);
      chk(mod_active, 1'h0);
      print_verdict();
   end
endmodule : tb
